// ---- common/pvl_regs.svh ----
// pvl_regs.svh - codes, resets, ranges and fields of the limit bank
// assumes: included through the package
// Operation
// R1 - lower limit bounds the effective target after any contributing change
// R2 - lower limit: unsigned mantissa, fixed exponent -9, code 10111
// R3 - effective minimum is mantissa times scale ratio times 2^-9 V
// R4 - clamp reference to scaled minimum while on; lower maximum wins
// R5 - clamp sets other fault, output warning, max/min warning, alert
// R6 - loop slave: lower limit ignored, nacked, invalid command fault, alert
// R7 - scale 1: lower limit resets to 179, valid 179 to 768
// R8 - scale 0.5: lower limit default 358, valid 358 to 1536
// R9 - scale 0.25: lower limit default 716, valid 716 to 3072
// R10 - run once input reaches start threshold and other conditions hold
// R11 - start threshold rounds to 0.25 V; outside 4.25-7.75 V rejected, flagged
// R12 - start exponent -2 (11110), mantissa default 18, range 17-31
// R13 - start threshold: only low four mantissa bits writable
// R14 - start threshold at or below stop threshold rejected, flagged
// R15 - stop running when input falls to stop threshold
// R16 - stop threshold rounds to step; outside 4-7.5 V rejected, flagged
// R17 - stop exponent -2 (11110), mantissa default 16, range 16-30
// R18 - stop threshold: only low mantissa bits writable
// R19 - scale ratio 1, 0.5 or 0.25: mantissa 4, 2 or 1, exponent -2
// R20 - re-check clamp after accepted writes; warn only when engaged while on
`ifndef PVL_REGS_SVH
`define PVL_REGS_SVH

`define PVL_CMD_MIN     8'h2b
`define PVL_CMD_VON     8'h35
`define PVL_CMD_VOFF    8'h36
`define PVL_SMB_ADDR    7'h2a
`define PVL_MIN_RST     16'h00b3
`define PVL_VON_RST     16'hf012
`define PVL_VOFF_RST    16'hf010
`define PVL_VIN_FIXED   16'hf010
`define PVL_MIN_LO_S1   16'h00b3
`define PVL_MIN_HI_S1   16'h0300
`define PVL_MIN_LO_S2   16'h0166
`define PVL_MIN_HI_S2   16'h0600
`define PVL_MIN_LO_S4   16'h02cc
`define PVL_MIN_HI_S4   16'h0c00
`define PVL_SCL_ONE     3'h4
`define PVL_SCL_HALF    3'h2
`define PVL_SCL_QTR     3'h1
`define PVL_VON_LO      32'sh0000_0011
`define PVL_VON_HI      32'sh0000_001f
`define PVL_VOFF_LO     32'sh0000_0010
`define PVL_VOFF_HI     32'sh0000_001e
`define PVL_Q_BAD       32'sh0000_7fff
`define PVL_LIN_EXP_MSB 15
`define PVL_LIN_EXP_LSB 11
`define PVL_LIN_MAN_MSB 10
`define PVL_Q_EXP_BIAS  2

`endif

// ---- common/pvl_pkg.sv ----
// pvl_pkg - types and shared arithmetic of the limit register bank
// assumes: pvl_regs.svh is on the include path
`include "pvl_regs.svh"

package pvl_pkg;

   typedef enum logic [5:0] {
      LS_IDLE = 6'h01,
      LS_RX   = 6'h02,
      LS_RACK = 6'h04,
      LS_WAIT = 6'h08,
      LS_TX   = 6'h10,
      LS_TACK = 6'h20
   } pvl_link_state_t;

   typedef enum logic {
      RK_CHECK = 1'b0,
      RK_WRITE = 1'b1
   } pvl_req_kind_t;

   // mantissa in 2^-9 V counts times the scale ratio (mantissa over four)
   function automatic logic [15:0] pvl_scale_ref(input logic [15:0] m, input logic [2:0] sc);
      logic [17:0] p;
      p = 18'(m) * 18'(sc);
      return p[17:2];
   endfunction

endpackage : pvl_pkg

// ---- logic/pvl_bit_sync.sv ----
// pvl_bit_sync - two flip-flop synchroniser for one level
// assumes: d may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none

module pvl_bit_sync (
   // clock
   input  wire logic clk,
   // level in and out
   input  wire logic d,
   output logic      q
);
   logic meta;

   // the first stage feeds only the second
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule // pvl_bit_sync

`default_nettype wire

// ---- logic/pvl_ref_clamp.sv ----
// pvl_ref_clamp - registered reference clamp against the scaled lower limit
// assumes: all inputs come from logic on clk
`timescale 1ns/1ps
`default_nettype none

module pvl_ref_clamp
   import pvl_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // settings
   input  wire logic        out_on,
   input  wire logic [15:0] target,
   input  wire logic [15:0] max_lim,
   input  wire logic [15:0] min_lim,
   input  wire logic [2:0]  scale,
   // result
   output logic [15:0]      ref_val,
   output logic             min_hit
);
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_val <= 16'h0000;
         min_hit <= 1'b0;
      end else begin
         min_hit <= out_on && (target < min_lim);                 // R1
         if (out_on && (target < min_lim)) begin
            if (max_lim < min_lim) begin
               ref_val <= pvl_scale_ref(max_lim, scale);          // R4
            end else begin
               ref_val <= pvl_scale_ref(min_lim, scale);          // R3
            end
         end else begin
            ref_val <= pvl_scale_ref(target, scale);
         end
      end
   end
endmodule // pvl_ref_clamp

`default_nettype wire

// ---- logic/pvl_limit_regs.sv ----
// pvl_limit_regs - lower limit and input thresholds behind an smbus slave
// assumes: bus pins are open drain and resolved outside; link_clk oversamples the bus pins;
// converter-side inputs come from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none

module pvl_limit_regs
   import pvl_pkg::*;
(
   // clocks and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        link_clk,
   // smbus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_n,
   output logic             sda_o,
   output logic             sda_oe_n,
   output logic             alert_o,
   output logic             alert_oe_n,
   // converter settings
   input  wire logic        loop_slave,
   input  wire logic        out_on,
   input  wire logic        start_ok,
   input  wire logic        tgt_update,
   input  wire logic        faults_clear,
   input  wire logic [15:0] vout_target,
   input  wire logic [15:0] vout_max_lim,
   input  wire logic [2:0]  scale_mant,
   input  wire logic [7:0]  vin_quarter,
   // converter results
   output logic [15:0]      ref_target,
   output logic             run_enable,
   // status
   output logic             other_fault_flag,
   output logic             output_fault_warn_flag,
   output logic             vout_minmax_warn,
   output logic             cml_flag,
   output logic             invalid_data_flag,
   output logic             invalid_command_fault
);

   // link domain
   logic                    link_rst;
   logic                    scl_s, sda_s, scl_d, sda_d;
   logic                    start_c, stop_c, rise_c, fall_c;
   pvl_link_state_t         l_state;
   logic [3:0]              bcnt;
   logic [7:0]              sh, tx_sh, wlo_reg, cmd_reg;
   logic [1:0]              idx;
   logic                    rd_mode, ack_reg, tx_hi;
   logic [15:0]             rd_buf, req_data;
   pvl_req_kind_t           req_kind;
   logic                    req_tgl, ans_s, ans_seen;

   // reference domain
   logic                    req_s, req_seen, req_new;
   logic                    ans_tgl, ans_ok;
   logic [15:0]             ans_rdata;
   logic [11:0]             min_reg;
   logic [3:0]              von_low, voff_low;
   logic                    init_reg;
   logic [2:0]              scale_prev;
   logic                    eval_d1, eval_d2, min_hit;
   logic                    is_chk, is_wr, known, blocked;
   logic                    min_wr, von_wr, voff_wr, bad_data, ivc_evt, clamp_evt;
   logic [15:0]             rd_val;
   int                      q_new, von_q, voff_q;

   function automatic logic [15:0] min_lo(input logic [2:0] sc);
      unique case (sc)
         `PVL_SCL_HALF: return `PVL_MIN_LO_S2;                    // R8
         `PVL_SCL_QTR:  return `PVL_MIN_LO_S4;                    // R9
         default:       return `PVL_MIN_LO_S1;                    // R7
      endcase
   endfunction

   function automatic logic [15:0] min_hi(input logic [2:0] sc);
      unique case (sc)
         `PVL_SCL_HALF: return `PVL_MIN_HI_S2;                    // R8
         `PVL_SCL_QTR:  return `PVL_MIN_HI_S4;                    // R9
         default:       return `PVL_MIN_HI_S1;                    // R7
      endcase
   endfunction

   // linear word to quarter volts, rounded half up; huge exponents are invalid unless the mantissa is zero
   function automatic int lin_to_q(input logic [15:0] w);
      int e;
      int m;
      int n;
      e = int'($signed(w[`PVL_LIN_EXP_MSB:`PVL_LIN_EXP_LSB]));
      m = int'($signed(w[`PVL_LIN_MAN_MSB:0]));
      n = e + `PVL_Q_EXP_BIAS;
      if (n > 4) begin
         return (m == 0) ? 0 : `PVL_Q_BAD;
      end else if (n >= 0) begin
         return m <<< n;
      end
      return (m + (1 <<< (-n - 1))) >>> (-n);                     // R11 R16
   endfunction

   // synchronisers
   pvl_bit_sync u_rst_sync (.clk(link_clk), .d(rst),     .q(link_rst));
   pvl_bit_sync u_scl_sync (.clk(link_clk), .d(scl_i),   .q(scl_s));
   pvl_bit_sync u_sda_sync (.clk(link_clk), .d(sda_i),   .q(sda_s));
   pvl_bit_sync u_ans_sync (.clk(link_clk), .d(ans_tgl), .q(ans_s));
   pvl_bit_sync u_req_sync (.clk(ref_clk),  .d(req_tgl), .q(req_s));

   always_ff @(posedge link_clk) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
   end

   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c  = scl_s & scl_d & ~sda_d & sda_s;
   assign rise_c  = scl_s & ~scl_d;
   assign fall_c  = ~scl_s & scl_d;

   // open-drain pins only ever pull low
   always_ff @(posedge link_clk) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
   end

   // byte engine for write word and read word
   // the clock is stretched while the reference side decides, so a nack can follow a command
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         l_state  <= LS_IDLE;
         bcnt     <= 4'h0;
         sh       <= 8'h00;
         tx_sh    <= 8'h00;
         wlo_reg  <= 8'h00;
         cmd_reg  <= 8'h00;
         idx      <= 2'h0;
         rd_mode  <= 1'b0;
         ack_reg  <= 1'b0;
         tx_hi    <= 1'b0;
         rd_buf   <= 16'h0000;
         req_data <= 16'h0000;
         req_kind <= RK_CHECK;
         req_tgl  <= 1'b0;
         ans_seen <= 1'b0;
         sda_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else if (stop_c) begin
         l_state  <= LS_IDLE;
         sda_oe_n <= 1'b1;
      end else if (start_c) begin
         l_state  <= LS_RX;
         bcnt     <= 4'h0;
         idx      <= 2'h0;
         sda_oe_n <= 1'b1;
      end else begin
         unique case (l_state)
            LS_IDLE: begin
               sda_oe_n <= 1'b1;
               scl_oe_n <= 1'b1;
            end
            LS_RX: begin
               if (rise_c && bcnt < 4'h8) begin
                  sh   <= {sh[6:0], sda_s};
                  bcnt <= bcnt + 4'h1;
               end else if (fall_c && bcnt == 4'h8) begin
                  unique case (idx)
                     2'h0: begin
                        rd_mode  <= sh[0];
                        ack_reg  <= (sh[7:1] == `PVL_SMB_ADDR);
                        sda_oe_n <= (sh[7:1] != `PVL_SMB_ADDR);
                        l_state  <= LS_RACK;
                     end
                     2'h1: begin
                        cmd_reg  <= sh;
                        req_kind <= RK_CHECK;
                        req_tgl  <= ~req_tgl;
                        scl_oe_n <= 1'b0;
                        l_state  <= LS_WAIT;
                     end
                     2'h2: begin
                        wlo_reg  <= sh;
                        ack_reg  <= 1'b1;
                        sda_oe_n <= 1'b0;
                        l_state  <= LS_RACK;
                     end
                     2'h3: begin
                        req_data <= {sh, wlo_reg};
                        req_kind <= RK_WRITE;
                        req_tgl  <= ~req_tgl;
                        scl_oe_n <= 1'b0;
                        l_state  <= LS_WAIT;
                     end
                  endcase
               end
            end
            LS_WAIT: begin
               if (ans_s != ans_seen) begin
                  ans_seen <= ans_s;
                  ack_reg  <= ans_ok;                             // R6
                  sda_oe_n <= ~ans_ok;
                  if (req_kind == RK_CHECK) begin
                     rd_buf <= ans_rdata;
                  end
                  l_state  <= LS_RACK;
               end
            end
            LS_RACK: begin
               scl_oe_n <= 1'b1;
               if (fall_c) begin
                  bcnt     <= 4'h0;
                  sda_oe_n <= 1'b1;
                  if (!ack_reg) begin
                     l_state <= LS_IDLE;
                  end else if (idx == 2'h0 && rd_mode) begin
                     tx_sh    <= rd_buf[7:0];
                     sda_oe_n <= rd_buf[7];
                     tx_hi    <= 1'b0;
                     l_state  <= LS_TX;
                  end else begin
                     idx     <= idx + 2'h1;
                     l_state <= LS_RX;
                  end
               end
            end
            LS_TX: begin
               if (rise_c) begin
                  bcnt <= bcnt + 4'h1;
               end else if (fall_c) begin
                  if (bcnt == 4'h8) begin
                     sda_oe_n <= 1'b1;
                     l_state  <= LS_TACK;
                  end else begin
                     tx_sh    <= {tx_sh[6:0], 1'b0};
                     sda_oe_n <= tx_sh[6];
                  end
               end
            end
            LS_TACK: begin
               if (rise_c) begin
                  ack_reg <= ~sda_s;
               end else if (fall_c) begin
                  if (ack_reg && !tx_hi) begin
                     tx_sh    <= rd_buf[15:8];
                     sda_oe_n <= rd_buf[15];
                     tx_hi    <= 1'b1;
                     bcnt     <= 4'h0;
                     l_state  <= LS_TX;
                  end else begin
                     l_state <= LS_IDLE;
                  end
               end
            end
            default: begin
               l_state  <= LS_IDLE;
               sda_oe_n <= 1'b1;
               scl_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // request decode; cmd_reg, req_kind and req_data stand still until answered
   assign req_new = req_s ^ req_seen;
   assign von_q   = int'({1'b1, von_low});
   assign voff_q  = int'({1'b1, voff_low});

   always_comb begin
      is_chk   = req_new && (req_kind == RK_CHECK);
      is_wr    = req_new && (req_kind == RK_WRITE);
      known    = (cmd_reg == `PVL_CMD_MIN) || (cmd_reg == `PVL_CMD_VON)
                 || (cmd_reg == `PVL_CMD_VOFF);
      blocked  = (cmd_reg == `PVL_CMD_MIN) && loop_slave;         // R6
      q_new    = lin_to_q(req_data);
      min_wr   = is_wr && !blocked && (cmd_reg == `PVL_CMD_MIN)
                 && (req_data >= min_lo(scale_mant))
                 && (req_data <= min_hi(scale_mant));             // R7 R8 R9
      von_wr   = is_wr && (cmd_reg == `PVL_CMD_VON)
                 && (q_new >= `PVL_VON_LO) && (q_new <= `PVL_VON_HI)
                 && (q_new > voff_q);                             // R11 R12 R14
      voff_wr  = is_wr && (cmd_reg == `PVL_CMD_VOFF)
                 && (q_new >= `PVL_VOFF_LO) && (q_new <= `PVL_VOFF_HI)
                 && (q_new < von_q);                              // R16 R17 R14
      bad_data = is_wr && known && !blocked && !(min_wr || von_wr || voff_wr);
      ivc_evt  = is_chk && (!known || blocked);                   // R6
      rd_val   = 16'h0000;
      if (cmd_reg == `PVL_CMD_MIN) begin
         rd_val = {4'h0, min_reg};                                // R2
      end else if (cmd_reg == `PVL_CMD_VON) begin
         rd_val = `PVL_VIN_FIXED | {12'h000, von_low};            // R13
      end else if (cmd_reg == `PVL_CMD_VOFF) begin
         rd_val = `PVL_VIN_FIXED | {12'h000, voff_low};           // R18
      end
   end

   // answer side of the handshake
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         req_seen  <= 1'b0;
         ans_tgl   <= 1'b0;
         ans_ok    <= 1'b0;
         ans_rdata <= 16'h0000;
      end else if (req_new) begin
         req_seen  <= req_s;
         ans_tgl   <= ~ans_tgl;
         ans_ok    <= is_wr || (known && !blocked);               // R6
         ans_rdata <= rd_val;
      end
   end

   // stored settings; the lower limit default follows the scale seen just after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         min_reg  <= 12'(`PVL_MIN_RST);                           // R7
         von_low  <= 4'(`PVL_VON_RST);                            // R12
         voff_low <= 4'(`PVL_VOFF_RST);                           // R17
         init_reg <= 1'b1;
      end else begin
         init_reg <= 1'b0;
         if (init_reg) begin
            min_reg <= 12'(min_lo(scale_mant));                   // R8 R9
         end else if (min_wr) begin
            min_reg <= req_data[11:0];
         end
         if (von_wr) begin
            von_low <= 4'(q_new);                                 // R13
         end
         if (voff_wr) begin
            voff_low <= 4'(q_new);                                // R18
         end
      end
   end

   pvl_ref_clamp u_clamp (
      .clk     (ref_clk),
      .rst     (rst),
      .out_on  (out_on),
      .target  (vout_target),
      .max_lim (vout_max_lim),
      .min_lim ({4'h0, min_reg}),
      .scale   (scale_mant),                                      // R19
      .ref_val (ref_target),
      .min_hit (min_hit)
   );

   // clamp re-check two edges after a lower limit write, target update or scale change, once the clamp register has caught up
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scale_prev <= `PVL_SCL_ONE;
         eval_d1    <= 1'b0;
         eval_d2    <= 1'b0;
      end else begin
         scale_prev <= scale_mant;
         eval_d1    <= min_wr || tgt_update || (scale_mant != scale_prev); // R20
         eval_d2    <= eval_d1;
      end
   end

   assign clamp_evt = eval_d2 && out_on && min_hit;               // R20

   // sticky status; a new event in the clearing cycle keeps its flag
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         other_fault_flag       <= 1'b0;
         output_fault_warn_flag <= 1'b0;
         vout_minmax_warn       <= 1'b0;
         cml_flag               <= 1'b0;
         invalid_data_flag      <= 1'b0;
         invalid_command_fault  <= 1'b0;
      end else begin
         other_fault_flag       <= clamp_evt || (other_fault_flag && !faults_clear);       // R5
         output_fault_warn_flag <= clamp_evt || (output_fault_warn_flag && !faults_clear); // R5
         vout_minmax_warn       <= clamp_evt || (vout_minmax_warn && !faults_clear);       // R5
         cml_flag               <= bad_data || ivc_evt || (cml_flag && !faults_clear);
         invalid_data_flag      <= bad_data || (invalid_data_flag && !faults_clear);       // R11 R16
         invalid_command_fault  <= ivc_evt || (invalid_command_fault && !faults_clear);    // R6
      end
   end

   // alert pulls low while any flag stands
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         alert_o    <= 1'b0;
         alert_oe_n <= 1'b1;
      end else begin
         alert_o    <= 1'b0;
         alert_oe_n <= !(other_fault_flag || output_fault_warn_flag || vout_minmax_warn
                         || cml_flag || invalid_data_flag || invalid_command_fault); // R5
      end
   end

   // run with hysteresis between the two thresholds
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_enable <= 1'b0;
      end else if (!run_enable && start_ok && (vin_quarter >= {3'h0, 1'b1, von_low})) begin
         run_enable <= 1'b1;                                      // R10
      end else if (run_enable && (vin_quarter <= {3'h0, 1'b1, voff_low})) begin
         run_enable <= 1'b0;                                      // R15
      end
   end

endmodule // pvl_limit_regs

`default_nettype wire

// ---- dv/pvl_limit_regs_sva.sv ----
// pvl_limit_regs_sva - converter-side checks of the limit bank
// assumes: bound into pvl_limit_regs; every check runs on ref_clk
`timescale 1ns/1ps
`default_nettype none
module pvl_limit_regs_sva (
   // clock, reset and converter side
   input wire logic        ref_clk, rst, out_on, start_ok, tgt_update, faults_clear,
   input wire logic [15:0] vout_target, vout_max_lim, ref_target,
   input wire logic [2:0]  scale_mant,
   input wire logic [7:0]  vin_quarter,
   // results and status
   input wire logic        run_enable, alert_oe_n, other_fault_flag, output_fault_warn_flag,
   input wire logic        vout_minmax_warn, cml_flag, invalid_data_flag, invalid_command_fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic any_flag = other_fault_flag | output_fault_warn_flag | vout_minmax_warn |
                         cml_flag | invalid_data_flag | invalid_command_fault;
   // every legal limit scales to 179 or more
   sequence low_target_s;
      out_on && tgt_update && scale_mant == 3'h4 && vout_target < 16'h00b3 &&
         vout_max_lim >= 16'h0c00;
   endsequence
   sequence warn_soon_s;
      ##[1:4] vout_minmax_warn;
   endsequence
   alert_follow_a: assert property (##1 alert_oe_n == !$past(any_flag))
      else $error("alert off flags");
   flag_sticky_a: assert property (cml_flag && !faults_clear |=> cml_flag)
      else $error("cml dropped");
   run_hold_a: assert property (!start_ok && !run_enable |=> !run_enable)
      else $error("run without start_ok");
   run_stop_a: assert property (vin_quarter <= 8'h10 |=> !run_enable)
      else $error("run below stop floor");
   ref_floor_a: assert property (out_on && scale_mant == 3'h4 && vout_max_lim >= 16'h0c00
      |=> ref_target >= 16'h00b3)
      else $error("ref under limit");
   clamp_warn_a: assert property (low_target_s |-> warn_soon_s)
      else $error("no clamp warning");
   warn_group_a: assert property ($rose(vout_minmax_warn)
      |-> other_fault_flag && output_fault_warn_flag)
      else $error("warnings split");
   ivd_cml_a: assert property ($rose(invalid_data_flag) |-> cml_flag)
      else $error("ivd without cml");
endmodule // pvl_limit_regs_sva
`default_nettype wire

// ---- dv/pvl_smb_host.sv ----
// pvl_smb_host - behavioural smbus host for the limit bank
// assumes: bench resolves both wires with pull-ups; scl idles high between frames
`timescale 1ns/1ps
`default_nettype none
module pvl_smb_host (
   // resolved wires in, host pull-downs out (1 = released)
   input  wire logic scl, sda,
   output var logic  scl_h, sda_h
);
   int hung = 0;
   initial {scl_h, sda_h} = 2'b11;
   // waits out clock stretching
   task automatic rise();
      scl_h = 1'b1;
      for (int k = 0; k < 500 && !scl; k++) #80;
      if (!scl) hung = 1;
      #500;
   endtask
   // data moves well after the fall, never with scl high
   task automatic bit_io(input logic b, output logic r);
      sda_h = b;
      #500;
      rise();
      r = sda;
      scl_h = 1'b0;
      #250;
   endtask
   task automatic start();
      sda_h = 1'b1;
      #250;
      rise();
      sda_h = 1'b0;
      #500;
      scl_h = 1'b0;
      #250;
   endtask
   task automatic stop();
      sda_h = 1'b0;
      #250;
      rise();
      sda_h = 1'b1;
      #1000;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                       output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ak, nak);
   endtask
endmodule // pvl_smb_host
`default_nettype wire

// ---- dv/test_pvl_limit_regs.sv ----
// test_pvl_limit_regs - self-checking bench for the limit bank
// assumes: package and design compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pvl_regs.svh"
module test_pvl_limit_regs;
   logic        ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, loop_slave = 1'b0;
   logic        out_on = 1'b0, start_ok = 1'b0, tgt_update = 1'b0, faults_clear = 1'b0;
   logic [15:0] vout_target = 16'h0400, vout_max_lim = 16'h0c00, ref_target, rd_val, tg;
   logic [2:0]  scale_mant = 3'h4;
   logic [7:0]  vin_quarter = 8'h00;
   logic        scl_h, sda_h, scl_o, scl_oe_n, sda_o, sda_oe_n, alert_o, alert_oe_n, nak;
   logic        run_enable, other_fault_flag, output_fault_warn_flag, vout_minmax_warn;
   logic        cml_flag, invalid_data_flag, invalid_command_fault;
   int          n_errors = 0, num_checks = 0, seed = 4791;
   logic [15:0] exp_q[$];
   event        rd_done;
   wire logic   scl_i = scl_h & (scl_oe_n | scl_o);
   wire logic   sda_i = sda_h & (sda_oe_n | sda_o);
   always #12.5 ref_clk = ~ref_clk;
   always #40 link_clk = ~link_clk;
   pvl_limit_regs uut (.*);
   pvl_smb_host host (.scl(scl_i), .sda(sda_i), .scl_h(scl_h), .sda_h(sda_h));
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
      logic [7:0] d;
      logic       a;
      host.start();
      host.xfer({`PVL_SMB_ADDR, 1'b0}, 1'b1, d, a);
      host.xfer(cmd, 1'b1, d, nak);
      host.xfer(v[7:0], 1'b1, d, a);
      host.xfer(v[15:8], 1'b1, d, a);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
      logic [7:0] d, lo, hi;
      logic       a;
      exp_q.push_back(e);
      host.start();
      host.xfer({`PVL_SMB_ADDR, 1'b0}, 1'b1, d, a);
      host.xfer(cmd, 1'b1, d, a);
      host.start();
      host.xfer({`PVL_SMB_ADDR, 1'b1}, 1'b1, d, a);
      host.xfer(8'hff, 1'b0, lo, a);
      host.xfer(8'hff, 1'b1, hi, a);
      host.stop();
      rd_val = {hi, lo};
      ->rd_done;
   endtask
   // clear or update pulse, then room for the clamp flags
   task automatic pulse(input bit clr);
      @(posedge ref_clk) #2;
      if (clr) faults_clear = 1'b1; else tgt_update = 1'b1;
      @(posedge ref_clk) #2;
      {faults_clear, tgt_update} = 2'b00;
      repeat (4) @(posedge ref_clk);
      #2;
   endtask
   always @(rd_done) chk("read word", rd_val, exp_q.pop_front());
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      logic [2:0]  sc[3] = '{3'h1, 3'h2, 3'h4};
      logic [15:0] dm[3] = '{`PVL_MIN_LO_S4, `PVL_MIN_LO_S2, `PVL_MIN_LO_S1};
      logic [7:0]  vt[4] = '{8'h15, 8'h15, 8'h11, 8'h10};
      bit          re[4] = '{0, 1, 1, 0};
      foreach (sc[i]) begin
         @(posedge ref_clk) #2;
         {rst, scale_mant} = {1'b1, sc[i]};
         repeat (12) @(posedge ref_clk);
         #2 rst = 1'b0;
         rd(`PVL_CMD_MIN, dm[i]);
      end
      rd(`PVL_CMD_VOFF, `PVL_VOFF_RST);
      wr(`PVL_CMD_VON, 16'hf020);
      chk("bad start", {cml_flag, invalid_data_flag}, 2'b11);
      rd(`PVL_CMD_VON, `PVL_VON_RST);
      pulse(1);
      wr(`PVL_CMD_VON, 16'he829);
      rd(`PVL_CMD_VON, 16'hf015);
      wr(`PVL_CMD_VOFF, 16'hf015);
      chk("order", invalid_data_flag, 1'b1);
      pulse(1);
      wr(`PVL_CMD_VOFF, 16'hf01f);
      chk("bad stop", invalid_data_flag, 1'b1);
      rd(`PVL_CMD_VOFF, `PVL_VOFF_RST);
      pulse(1);
      wr(`PVL_CMD_MIN, 16'h0301);
      chk("bad min", invalid_data_flag, 1'b1);
      wr(`PVL_CMD_MIN, 16'h0200);
      pulse(1);
      tg = 16'h0300 + 16'($random(seed) & 255);
      {out_on, vout_target} = {1'b1, tg};
      pulse(0);
      chk("ref", ref_target, tg);
      chk("quiet", vout_minmax_warn, 1'b0);
      vout_target = 16'h0064;
      pulse(0);
      chk("clamp", ref_target, 16'h0200);
      chk("warn", {other_fault_flag, output_fault_warn_flag, vout_minmax_warn}, 3'h7);
      vout_max_lim = 16'h012c;
      pulse(0);
      chk("max wins", ref_target, 16'h012c);
      pulse(1);
      loop_slave = 1'b1;
      wr(`PVL_CMD_MIN, 16'h0100);
      chk("nack", {nak, invalid_command_fault}, 2'b11);
      loop_slave = 1'b0;
      rd(`PVL_CMD_MIN, 16'h0200);
      foreach (vt[i]) begin
         @(posedge ref_clk) #2;
         {vin_quarter, start_ok} = {vt[i], i > 0};
         repeat (3) @(posedge ref_clk);
         chk("run", run_enable, re[i]);
      end
      chk("stretch", 16'(host.hung), 16'h0000);
      end_of_test();
   end
endmodule // test_pvl_limit_regs
bind pvl_limit_regs pvl_limit_regs_sva chk_i (.*);
`default_nettype wire
